// >>> bench/ggt_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the link: mode 1 master, link clock stands still between frames
module ggt_host_model #(
  parameter int HALF = 15            // Half period of the 30 ns link clock
) (
  output logic      sclk_o,          // Link clock, idles low
  output logic      cs_n_o,          // Frame select, active low
  output logic      din_o,           // Data towards the device
  input  wire logic dout_i           // Data from the device
);
  // Idle link after time zero
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  // Shifts nbits out MSB first; the last byte seen on dout_i is returned
  task automatic xfer(input logic [23:0] frame, input int nbits, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    cs_n_o = 1'b0;
    #(HALF);
    for (i = 0; i < nbits; i++) begin
      sclk_o = 1'b1;
      din_o  = frame[23-i];          // Launch on rising edges only
      #(HALF);
      sclk_o = 1'b0;
      rd = {rd[6:0], dout_i};        // Capture on falling edges
      #(HALF);
    end
    cs_n_o = 1'b1;
    din_o  = ~din_o;                 // Released line never shows a stale level
    #(4*HALF);
  endtask : xfer
endmodule : ggt_host_model

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ggt_cfg.svh"

// Self-checking bench: random register traffic over the link
module tb_top;
  import ggt_pkg::*;
  logic      clk_sys, rst, sclk, cs_n, din, dout, dout_oe;
  ggt_pins_t gpio_i, gpio_o, gpio_oe, pin_analog, pads;
  ggt_gain_t gain;
  logic [7:0] hi, lo, fn, lv, rd;
  int        fails, n_checks, k;

  // 40 MHz system clock
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  ggt_trim_gpio dut_u (
    .CLK_SYS_I(clk_sys), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
    .DOUT_O(dout), .DOUT_OE_O(dout_oe), .GPIO_I(gpio_i), .GPIO_O(gpio_o),
    .GPIO_OE_O(gpio_oe), .PIN_ANALOG_O(pin_analog), .GAIN_TRIM_O(gain));
  ggt_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Write frame, then let the request cross into the system domain
  task automatic wr(input ggt_addr_t a, input ggt_byte_t d);
    logic [7:0] r;
    host_u.xfer({3'b000, a, d, 8'h00}, 16, r);
    repeat (8) @(negedge clk_sys);
  endtask : wr

  task automatic rchk(input string what, input ggt_addr_t a, input ggt_byte_t e);
    logic [7:0] d;
    host_u.xfer({3'b100, a, 16'h0000}, 24, d);
    chk(what, {8'h00, e}, {8'h00, d});
  endtask : rchk

  // Pin outputs packed as {0, enables, levels, analog}
  function automatic logic [15:0] pins_exp(input logic [7:0] f, input logic [7:0] l);
    ggt_pins_t oe;
    oe = f[3:0] & ~l[7:4];
    return {4'h0, oe, l[3:0] & oe, ~f[3:0]};
  endfunction : pins_exp

  // Level readback: digital inputs return the pads, others the stored bits
  function automatic logic [7:0] lvl_exp(input logic [7:0] f, input logic [7:0] l,
                                         input ggt_pins_t p);
    ggt_pins_t in;
    in = f[3:0] & l[7:4];
    return {l[7:4], (in & p) | (~in & l[3:0])};
  endfunction : lvl_exp

  // Output data may only move just after a rising link edge
  always @(dout) begin
    if (!cs_n && sclk !== 1'b1) begin
      fails++;
      $display("[ERR] dout edge expected rising seen %b", sclk);
    end
  end

  // Watchdog cuts a hang short
  initial begin
    #1000000;
    fails++;
    $display("[ERR] run time expected below limit seen over");
    end_sim();
  end

  initial begin
    rst = 1'b1;
    gpio_i = 4'h0;
    fails = 0;
    n_checks = 0;
    void'($urandom(18467));
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("gain_rst", 16'h4000, gain);
    chk("pins_rst", pins_exp(8'h00, 8'h00), {4'h0, gpio_oe, gpio_o, pin_analog});
    chk("dout_oe", 16'h0000, {15'h0000, dout_oe});
    rchk("hi_rst", `GGT_ADDR_GAIN_HI, 8'h40);
    rchk("lo_rst", `GGT_ADDR_GAIN_LO, 8'h00);
    rchk("lvl_rst", `GGT_ADDR_LEVEL, 8'h00);
    rchk("fn_rst", `GGT_ADDR_FUNC, 8'h00);
    // Gain bytes, first pass at the corners
    for (k = 0; k < 6; k++) begin
      hi = (k == 0) ? 8'hFF : 8'($urandom());
      lo = (k == 0) ? 8'h00 : 8'($urandom());
      wr(`GGT_ADDR_GAIN_HI, hi);
      wr(`GGT_ADDR_GAIN_LO, lo);
      chk("gain", {hi, lo}, gain);
      rchk("hi", `GGT_ADDR_GAIN_HI, hi);
      rchk("lo", `GGT_ADDR_GAIN_LO, lo);
    end
    // Pin setups with stray upper function bits and random pads
    for (k = 0; k < 8; k++) begin
      fn = (k == 0) ? 8'hF0 : 8'($urandom());
      lv = 8'($urandom());
      pads = 4'($urandom());
      @(negedge clk_sys);
      gpio_i = pads;
      wr(`GGT_ADDR_FUNC, fn);
      wr(`GGT_ADDR_LEVEL, lv);
      chk("pins", pins_exp(fn, lv), {4'h0, gpio_oe, gpio_o, pin_analog});
      rchk("fn", `GGT_ADDR_FUNC, {4'h0, fn[3:0]});
      rchk("lvl", `GGT_ADDR_LEVEL, lvl_exp(fn, lv, pads));
    end
    // Unmapped place and a frame cut short leave the gain alone
    wr(5'h12, 8'hA5);
    rchk("unmapped", 5'h12, 8'h00);
    host_u.xfer({3'b000, `GGT_ADDR_GAIN_HI, ~hi, 8'h00}, 12, rd);
    repeat (8) @(negedge clk_sys);
    chk("gain_abort", {hi, lo}, gain);
    // Second reset in mid-run restores the defaults
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("gain_rst2", 16'h4000, gain);
    chk("pins_rst2", pins_exp(8'h00, 8'h00), {4'h0, gpio_oe, gpio_o, pin_analog});
    end_sim();
  end
endmodule : tb_top

`default_nettype wire

// >>> logic/ggt_cfg.svh
`ifndef GGT_CFG_SVH
`define GGT_CFG_SVH

// Register addresses on the serial link
`define GGT_ADDR_GAIN_LO   5'h0E
`define GGT_ADDR_GAIN_HI   5'h0F
`define GGT_ADDR_LEVEL     5'h10
`define GGT_ADDR_FUNC      5'h11

// Reset values
`define GGT_GAIN_LO_RST    8'h00
`define GGT_GAIN_HI_RST    8'h40
`define GGT_LEVEL_RST      8'h00
`define GGT_FUNC_RST       4'h0

// Field positions inside the pin level register
`define GGT_DIR_MSB        7
`define GGT_DIR_LSB        4
`define GGT_LVL_MSB        3
`define GGT_LVL_LSB        0

// Command byte layout: read flag, then address in the low bits
`define GGT_CMD_READ_BIT   7
`define GGT_CMD_ADDR_MSB   4

// Frame bit counts
`define GGT_CMD_BITS       5'h08
`define GGT_WRITE_BITS     5'h10
`define GGT_READ_LOAD_BITS 5'h10
`define GGT_CNT_MAX        5'h1F

`endif

// >>> logic/ggt_link_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "ggt_cfg.svh"

// Serial slave in the link clock domain: shifts frames, posts requests
module ggt_link_end (
  input  wire logic  sclk_i,    // Link clock, idles low
  input  wire logic  rst_i,     // Asynchronous reset, active high
  input  wire logic  cs_n_i,    // Frame select, active low
  input  wire logic  din_i,     // Serial data in
  output logic       dout_o,    // Serial data out
  ggt_xfer_if.link   xfer       // Requests towards the register side
);
  import ggt_pkg::*;

  logic [4:0] cnt;
  logic [7:0] rx_sh;
  logic [7:0] cmd;
  logic [7:0] tx_sh;
  logic       ack_s1;
  logic       ack_s2;

  // Frame end clears the bit state without needing an edge
  wire       frame_rst  = rst_i | cs_n_i;
  wire [4:0] next_cnt   = (cnt == `GGT_CNT_MAX) ? cnt : cnt + 5'h01;
  wire [7:0] next_rx    = {rx_sh[6:0], din_i};
  wire       cmd_done   = (next_cnt == `GGT_CMD_BITS) && (cnt != next_cnt);
  wire       wr_done    = (next_cnt == `GGT_WRITE_BITS) && (cnt != next_cnt);
  wire       is_read    = (cmd[`GGT_CMD_READ_BIT] == GGT_CMD_READ);
  wire       rd_ready   = (ack_s2 == xfer.rd_req_tgl);
  wire       load_tx    = (cnt == `GGT_READ_LOAD_BITS);

  // Sample on falling edges, count bits of the frame
  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      cnt   <= 5'h00;
      rx_sh <= 8'h00;
      cmd   <= 8'h00;
    end else begin
      cnt   <= next_cnt;
      rx_sh <= next_rx;
      if (cmd_done) cmd <= next_rx;
    end
  end

  // Post write and read requests; toggles survive the frame end
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer.wr_req_tgl <= 1'b0;
      xfer.wr_addr    <= 5'h00;
      xfer.wr_data    <= 8'h00;
      xfer.rd_req_tgl <= 1'b0;
      xfer.rd_addr    <= 5'h00;
    end else if (!cs_n_i) begin
      if (cmd_done && next_rx[`GGT_CMD_READ_BIT]) begin
        xfer.rd_addr    <= next_rx[`GGT_CMD_ADDR_MSB:0];
        xfer.rd_req_tgl <= ~xfer.rd_req_tgl;
      end
      if (wr_done && !is_read) begin
        xfer.wr_addr    <= cmd[`GGT_CMD_ADDR_MSB:0];
        xfer.wr_data    <= next_rx;
        xfer.wr_req_tgl <= ~xfer.wr_req_tgl;
      end
    end
  end

  // Acknowledge crossing from the system clock, two flip-flops
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= xfer.rd_ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // Launch data on rising edges; third byte of a read carries the register
  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      tx_sh <= 8'h00;
    end else if (load_tx) begin
      tx_sh <= (is_read && rd_ready) ? xfer.rd_data : 8'h00;
    end else begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  assign dout_o = tx_sh[7];

  a_mode1_launch: assert property (@(posedge sclk_i) disable iff (frame_rst)
    load_tx && is_read && rd_ready |=> dout_o == $past(xfer.rd_data[7]))
    else $error("read data not launched on the rising edge");

  c_read_frame: cover property (@(posedge sclk_i) disable iff (frame_rst)
    load_tx && is_read && rd_ready);
endmodule : ggt_link_end

`default_nettype wire

// >>> logic/ggt_pkg.sv
package ggt_pkg;
  typedef logic [4:0]  ggt_addr_t;
  typedef logic [7:0]  ggt_byte_t;
  typedef logic [15:0] ggt_gain_t;
  typedef logic [3:0]  ggt_pins_t;

  // Meaning of the command flag bit
  typedef enum logic {
    GGT_CMD_WRITE = 1'b0,
    GGT_CMD_READ  = 1'b1
  } ggt_cmd_e;
endpackage : ggt_pkg

// >>> logic/ggt_trim_gpio.sv
// Behaviour
// - Gain trim high byte, read/write, resets 40h
// - Gain trim low byte, read/write, resets 00h
// - Direction bits 7:4, zero output, one input
// - Level bits 3:0 drive outputs, return inputs
// - Function bit selects analog or digital pin
// - Pins stay disabled until function bit set
// - Link uses mode 1 clocking on both ends
`timescale 1ns/1ps
`default_nettype none
`include "ggt_cfg.svh"

// Gain trim and general-purpose pin registers behind a serial link
module ggt_trim_gpio #(
  parameter int  NPINS           = 4,       // Number of pads filtered into pin_state; pin ports are fixed at 4 bits
  parameter bit  REDUCED_CHANNEL = 1'b0     // Reduced-channel variant flag, read only by the c_reduced cover
) (
  input  wire logic        CLK_SYS_I,       // System clock, 40 MHz
  input  wire logic        RST_I,           // Asynchronous reset, active high
  input  wire logic        SCLK_I,          // Link clock from host
  input  wire logic        CS_N_I,          // Frame select, active low
  input  wire logic        DIN_I,           // Serial data from host
  output logic             DOUT_O,          // Serial data to host
  output logic             DOUT_OE_O,       // Serial output enable
  input  wire ggt_pkg::ggt_pins_t GPIO_I,   // Pin levels seen at pads
  output ggt_pkg::ggt_pins_t      GPIO_O,   // Pin levels driven
  output ggt_pkg::ggt_pins_t      GPIO_OE_O,// Pin output enables
  output ggt_pkg::ggt_pins_t      PIN_ANALOG_O, // Pin routed to analog input
  output ggt_pkg::ggt_gain_t      GAIN_TRIM_O   // Gain trim value
);
  import ggt_pkg::*;

  ggt_xfer_if xfer ();

  // Link clock domain logic
  ggt_link_end u_link (
    .sclk_i (SCLK_I),
    .rst_i  (RST_I),
    .cs_n_i (CS_N_I),
    .din_i  (DIN_I),
    .dout_o (DOUT_O),
    .xfer   (xfer.link)
  );

  // Output enable follows the frame select
  assign DOUT_OE_O = ~CS_N_I;

  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic       wr_seen;
  logic       rd_seen;
  ggt_byte_t  gain_lo;
  ggt_byte_t  gain_hi;
  ggt_byte_t  level_reg;
  ggt_pins_t  func;
  ggt_pins_t  pin_s1;
  ggt_pins_t  pin_s2;
  ggt_pins_t  pin_s3;
  ggt_pins_t  pin_state;
  ggt_byte_t  rd_data;
  logic       rd_ack;

  // Request toggles pass three flip-flops; agreement of the last two counts
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
    end else begin
      wr_sync <= {wr_sync[1:0], xfer.wr_req_tgl};
      rd_sync <= {rd_sync[1:0], xfer.rd_req_tgl};
    end
  end

  wire wr_evt = (wr_sync[1] == wr_sync[2]) && (wr_sync[2] != wr_seen);
  wire rd_evt = (rd_sync[1] == rd_sync[2]) && (rd_sync[2] != rd_seen);

  // Remember which toggle level was last served
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      wr_seen <= 1'b0;
      rd_seen <= 1'b0;
    end else begin
      if (wr_evt) wr_seen <= wr_sync[2];
      if (rd_evt) rd_seen <= rd_sync[2];
    end
  end

  // Write address decode
  wire hit_lo   = wr_evt && (xfer.wr_addr == `GGT_ADDR_GAIN_LO);
  wire hit_hi   = wr_evt && (xfer.wr_addr == `GGT_ADDR_GAIN_HI);
  wire hit_lvl  = wr_evt && (xfer.wr_addr == `GGT_ADDR_LEVEL);
  wire hit_func = wr_evt && (xfer.wr_addr == `GGT_ADDR_FUNC);

  // Gain trim bytes
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      gain_hi <= `GGT_GAIN_HI_RST;
      gain_lo <= `GGT_GAIN_LO_RST;
    end else begin
      if (hit_hi) gain_hi <= xfer.wr_data;
      if (hit_lo) gain_lo <= xfer.wr_data;
    end
  end

  assign GAIN_TRIM_O = {gain_hi, gain_lo};

  // Pin level, direction and function registers
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      level_reg <= `GGT_LEVEL_RST;
      func      <= `GGT_FUNC_RST;
    end else begin
      if (hit_lvl)  level_reg <= xfer.wr_data;
      if (hit_func) func      <= xfer.wr_data[3:0];
    end
  end

  // Pad inputs pass three flip-flops; a change counts once the last two agree
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1    <= 4'h0;
      pin_s2    <= 4'h0;
      pin_s3    <= 4'h0;
      pin_state <= 4'h0;
    end else begin
      pin_s1 <= GPIO_I;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < NPINS; i++) begin
        if (pin_s2[i] == pin_s3[i]) pin_state[i] <= pin_s3[i];
      end
    end
  end

  // Pin control: digital use only when its function bit is set
  wire [3:0] dir        = level_reg[`GGT_DIR_MSB:`GGT_DIR_LSB];
  wire [3:0] lvl        = level_reg[`GGT_LVL_MSB:`GGT_LVL_LSB];
  wire [3:0] is_input   = func & dir;
  wire [3:0] is_output  = func & ~dir;
  wire [3:0] lvl_view   = (is_input & pin_state) | (~is_input & lvl);

  assign GPIO_OE_O    = is_output;
  assign GPIO_O       = lvl & is_output;
  assign PIN_ANALOG_O = ~func;

  // Read data selection; unmapped addresses return zero
  wire [7:0] rd_mux =
    (xfer.rd_addr == `GGT_ADDR_GAIN_LO) ? gain_lo :
    (xfer.rd_addr == `GGT_ADDR_GAIN_HI) ? gain_hi :
    (xfer.rd_addr == `GGT_ADDR_LEVEL)   ? {dir, lvl_view} :
    (xfer.rd_addr == `GGT_ADDR_FUNC)    ? {4'h0, func} :
    8'h00;

  // Capture read data and acknowledge towards the link in the same cycle
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      rd_data <= 8'h00;
      rd_ack  <= 1'b0;
    end else if (rd_evt) begin
      rd_data <= rd_mux;
      rd_ack  <= rd_sync[2];
    end
  end

  assign xfer.rd_data    = rd_data;
  assign xfer.rd_ack_tgl = rd_ack;

  // Checks on the register side
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  a_gain_hi_write: assert property (
    hit_hi |=> GAIN_TRIM_O[15:8] == $past(xfer.wr_data))
    else $error("gain trim high byte not updated");

  a_gain_hi_hold: assert property (
    !hit_hi && !$past(RST_I) |=> $stable(GAIN_TRIM_O[15:8]))
    else $error("gain trim high byte changed without a write");

  a_gain_lo_write: assert property (
    hit_lo |=> GAIN_TRIM_O[7:0] == $past(xfer.wr_data)
               && $stable(GAIN_TRIM_O[15:8]))
    else $error("gain trim low byte not updated");

  a_dir_output: assert property (
    hit_lvl && !xfer.wr_data[4] && func[0] |=> GPIO_OE_O[0])
    else $error("pin 0 not driven after output direction");

  a_dir_input: assert property (
    hit_lvl && xfer.wr_data[5] |=> !GPIO_OE_O[1])
    else $error("pin 1 driven while set as input");

  a_level_out: assert property (
    hit_lvl && !xfer.wr_data[6] && func[2] && !hit_func
    |=> GPIO_O[2] == $past(xfer.wr_data[2]))
    else $error("pin 2 level not driven from register");

  a_level_in: assert property (
    rd_evt && xfer.rd_addr == `GGT_ADDR_LEVEL && is_input[3]
    |=> rd_data[3] == $past(pin_state[3]))
    else $error("input pin 3 level not returned");

  a_func_analog: assert property (
    hit_func && !xfer.wr_data[1] |=> PIN_ANALOG_O[1] && !GPIO_OE_O[1] ##1 !GPIO_OE_O[1])
    else $error("pin 1 still digital after analog select");

  a_pins_idle: assert property (
    $past(RST_I) |-> GPIO_OE_O == 4'h0 && GPIO_O == 4'h0)
    else $error("pins active straight after reset");

  a_func_upper: assert property (
    rd_evt && xfer.rd_addr == `GGT_ADDR_FUNC |=> rd_data[7:4] == 4'h0)
    else $error("function register upper bits not zero");

  a_write_lat: assert property (
    $changed(xfer.wr_req_tgl) |-> ##[2:4] wr_seen == xfer.wr_req_tgl)
    else $error("write request not served in time");

  // Registers only move on their own write strobe
  a_gain_lo_hold: assert property (
    !hit_lo && !$past(RST_I) |=> $stable(GAIN_TRIM_O[7:0]))
    else $error("gain trim low byte changed without a write");

  a_level_hold: assert property (
    !hit_lvl && !$past(RST_I) |=> $stable(level_reg))
    else $error("pin level register changed without a write");

  a_func_hold: assert property (
    !hit_func && !$past(RST_I) |=> $stable(func))
    else $error("pin function bits changed without a write");

  a_rst_values: assert property (
    $past(RST_I) |-> GAIN_TRIM_O == {`GGT_GAIN_HI_RST, `GGT_GAIN_LO_RST} && PIN_ANALOG_O == 4'hF)
    else $error("reset values not present after reset");

  a_func_write: assert property (
    hit_func |=> func == $past(xfer.wr_data[3:0]))
    else $error("pin function bits not updated");

  a_level_write: assert property (
    hit_lvl |=> level_reg == $past(xfer.wr_data))
    else $error("pin level register not updated");

  // Read data taken from the addressed register
  a_read_gain_hi: assert property (
    rd_evt && xfer.rd_addr == `GGT_ADDR_GAIN_HI |=> rd_data == $past(gain_hi))
    else $error("gain trim high byte read back wrong");

  a_read_gain_lo: assert property (
    rd_evt && xfer.rd_addr == `GGT_ADDR_GAIN_LO |=> rd_data == $past(gain_lo))
    else $error("gain trim low byte read back wrong");

  a_read_dir: assert property (
    rd_evt && xfer.rd_addr == `GGT_ADDR_LEVEL |=> rd_data[7:4] == $past(level_reg[7:4]))
    else $error("direction bits read back wrong");

  a_read_level_out: assert property (
    rd_evt && xfer.rd_addr == `GGT_ADDR_LEVEL && !is_input[1] |=> rd_data[1] == $past(lvl[1]))
    else $error("stored level of pin 1 read back wrong");

  a_read_func_low: assert property (
    rd_evt && xfer.rd_addr == `GGT_ADDR_FUNC |=> rd_data[3:0] == $past(func))
    else $error("function bits read back wrong");

  // Pin drive follows function and direction at all times
  a_analog_quiet: assert property (
    PIN_ANALOG_O[0] |-> !GPIO_OE_O[0] && !GPIO_O[0])
    else $error("analog pin 0 driven");

  a_input_undriven: assert property (
    func[2] && level_reg[6] |-> !GPIO_OE_O[2])
    else $error("input pin 2 driven");

  a_low_level: assert property (
    !level_reg[3] |-> !GPIO_O[3])
    else $error("pin 3 driven high with level bit clear");

  a_digital_select: assert property (
    func[3] |-> !PIN_ANALOG_O[3])
    else $error("pin 3 still analog with function bit set");

  a_pad_filter: assert property (
    pin_s2[0] != pin_s3[0] |=> $stable(pin_state[0]))
    else $error("pad 0 accepted before two stages agree");

  c_gain_write: cover property (hit_hi ##1 hit_lo);
  c_pin_input: cover property (rd_evt && xfer.rd_addr == `GGT_ADDR_LEVEL && is_input != 4'h0);
  c_pin_enable: cover property (hit_func ##[1:50] GPIO_OE_O != 4'h0);
  c_reduced: cover property (REDUCED_CHANNEL && hit_func);
endmodule : ggt_trim_gpio

`default_nettype wire

// >>> logic/ggt_xfer_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries register requests between the link clock and the system clock
interface ggt_xfer_if;
  import ggt_pkg::*;
  logic      wr_req_tgl;   // Flips once per completed write
  ggt_addr_t wr_addr;      // Write address, stable while toggle is in flight
  ggt_byte_t wr_data;      // Write data
  logic      rd_req_tgl;   // Flips once per read request
  ggt_addr_t rd_addr;      // Read address
  logic      rd_ack_tgl;   // Follows rd_req_tgl once rd_data is valid
  ggt_byte_t rd_data;      // Read data from the register side

  modport link (output wr_req_tgl, wr_addr, wr_data, rd_req_tgl, rd_addr,
                input rd_ack_tgl, rd_data);
  modport core (input wr_req_tgl, wr_addr, wr_data, rd_req_tgl, rd_addr,
                output rd_ack_tgl, rd_data);
endinterface : ggt_xfer_if

`default_nettype wire
